// >>> src/ste_trap_entry.sv
// Supervisor trap entry: cause capture, vector address, arbitration, latency
// Function
// - On every trap, load the cause register with the responsible event code.
// - Interrupt trap sets cause bit 63, low bits hold the pending-bit number.
// - Synchronous exception clears bit 63, code goes in bits 62 to 0.
// - Supervisor interrupt codes: software 1, timer 5, external 9.
// - Exception codes 0-3, 5-8, 12, 13, 15 as assigned; others reserved.
// - Mode 0: every trap goes to the vector base address.
// - Mode 1: interrupts go to base plus four times the cause code.
// - Vector register keeps base bits 63 to 2; bits 1 to 0 read the mode, 0 or 1.
// - Supervisor global interrupts report code 9, vector offset 0x24.
// - An enabled local interrupt beats a global one in the same cycle.
// - Among locals the highest identifier wins, 47 highest.
// - Local 47 has the largest code, the last vector slot.
// - Order: locals 47..0, M global, M sw, M timer, S global, S sw, S timer.
// - Four core cycles from interrupt to first handler fetch.
// - Global interrupts add three controller user-clock cycles of latency.
// - A divide in flight is kept; a dependent handler stalls until done.
// - The global input is fed by a 186-source, 7-level controller.
// - Pending bit 9 shows the supervisor external interrupt.
`default_nettype none
module ste_trap_entry
	import ste_pkg::*;
#(
	parameter int USER_RATIO = 1                       // Core clocks per user clock
) (
	input  wire logic              clk_i,              // Core clock
	input  wire logic              rst_i,              // Sync reset, high
	input  wire logic              ce_i,               // Clock enable
	input  wire ste_wb_req_t       wb_i,               // Wishbone request
	output logic [31:0]            wb_dat_o,           // Wishbone read data
	output logic                   wb_ack_o,           // Wishbone ack
	input  wire logic [47:0]       local_irq_i,        // Local interrupt lines
	input  wire ste_glb_t          glb_irq_i,          // Global/core interrupt lines
	input  wire logic              exc_valid_i,        // Synchronous exception
	input  wire logic [4:0]        exc_code_i,         // Exception code
	input  wire logic              trap_ret_i,         // Handler returned
	input  wire logic              div_busy_i,         // Divide in execute
	input  wire logic [4:0]        div_rd_i,           // Divide destination
	input  wire logic              hdl_rs_valid_i,     // Handler reads a register
	input  wire logic [4:0]        hdl_rs_i,           // Register read by handler
	output logic                   trap_taken_o,       // Trap accepted pulse
	output logic                   trap_irq_o,         // Taken trap was interrupt
	output logic [63:0]            handler_pc_o,       // Handler address
	output logic                   fetch_req_o,        // First handler fetch pulse
	output logic                   stall_o             // Divide dependency stall
);
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	localparam logic [15:0] GLB_DLY = 16'(CTRL_USER_CYC * USER_RATIO);

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [62:0] local_code(input logic [47:0] v);
		logic [62:0] c;
		c = CODE_LOCAL0;
		for (int i = 0; i < NUM_LOCAL; i++) begin
			if (v[i]) begin
				c = CODE_LOCAL0 + 63'(i);
			end
		end
		return c;
	endfunction

	function automatic logic legal_exc(input logic [4:0] c);
		unique case (c)
			EXC_FETCH_MIS, EXC_FETCH_ACC, EXC_ILLEGAL, EXC_BREAK, EXC_LOAD_ACC,
			EXC_STORE_MIS, EXC_STORE_ACC, EXC_ECALL_U, EXC_FETCH_PF, EXC_LOAD_PF,
			EXC_STORE_PF: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [47:0] loc_s1_r;
	logic [47:0] loc_s2_r;
	ste_glb_t    glb_s1_r;
	ste_glb_t    glb_s2_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			loc_s1_r <= '0;
			loc_s2_r <= '0;
			glb_s1_r <= '0;
			glb_s2_r <= '0;
		end else if (ce_i) begin
			loc_s1_r <= local_irq_i;
			loc_s2_r <= loc_s1_r;
			glb_s1_r <= glb_irq_i;
			glb_s2_r <= glb_s1_r;
		end
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [63:0] cause_r;
	logic [63:2] vec_base_r;
	logic [1:0]  vec_mode_r;
	logic [47:0] len_r;
	logic [5:0]  gen_r;
	ste_state_t  state_r;
	logic [2:0]  cnt_r;
	logic [15:0] glb_cnt_r;

	logic        wb_hit;
	logic        wb_wr;
	logic [63:0] vec_full;
	logic [31:0] vec_lo_nxt;

	assign wb_hit     = wb_i.cyc & wb_i.stb & ~wb_ack_o;
	assign wb_wr      = wb_hit & wb_i.we;
	assign vec_full   = {vec_base_r, vec_mode_r};
	assign vec_lo_nxt = merge(vec_full[31:0], wb_i.dat, wb_i.sel);

	// ---------------------------------------------------------------
	// Arbitration
	// ---------------------------------------------------------------
	logic [47:0] loc_act;
	ste_glb_t    glb_act;
	logic        glb_ready;
	logic        irq_any;
	logic [62:0] irq_code;
	logic        exc_ok;
	logic        take;

	assign loc_act   = loc_s2_r & len_r;
	assign glb_act   = glb_s2_r & gen_r;
	assign glb_ready = (glb_cnt_r >= GLB_DLY);
	assign exc_ok    = exc_valid_i & legal_exc(exc_code_i);
	assign irq_any   = (|loc_act) | (glb_ready & (|glb_act));
	assign take      = (state_r == ST_IDLE) & (exc_ok | irq_any);

	always_comb begin
		irq_code = CODE_S_TIM;
		if (|loc_act) begin
			irq_code = local_code(loc_act);
		end else if (glb_act.m_ext) begin
			irq_code = CODE_M_EXT;
		end else if (glb_act.m_sw) begin
			irq_code = CODE_M_SW;
		end else if (glb_act.m_tim) begin
			irq_code = CODE_M_TIM;
		end else if (glb_act.s_ext) begin
			irq_code = CODE_S_EXT;
		end else if (glb_act.s_sw) begin
			irq_code = CODE_S_SW;
		end else begin
			irq_code = CODE_S_TIM;
		end
	end

	// Global lines must stand for the controller's user-clock delay
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			glb_cnt_r <= '0;
		end else if (ce_i) begin
			if (~|glb_act) begin
				glb_cnt_r <= '0;
			end else if (~glb_ready) begin
				glb_cnt_r <= glb_cnt_r + 16'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Cause register
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cause_r <= CAUSE_RST;
		end else if (ce_i) begin
			if (take & irq_any) begin
				cause_r <= {1'b1, irq_code};
			end else if (take) begin
				cause_r <= {1'b0, 58'h0, exc_code_i};
			end else if (wb_wr && wb_i.adr == OFS_CAUSE_LO) begin
				cause_r[31:0] <= merge(cause_r[31:0], wb_i.dat, wb_i.sel);
			end else if (wb_wr && wb_i.adr == OFS_CAUSE_HI) begin
				cause_r[63:32] <= merge(cause_r[63:32], wb_i.dat, wb_i.sel);
			end
		end
	end

	// ---------------------------------------------------------------
	// Vector and enable registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			vec_base_r <= VEC_RST[63:2];
			vec_mode_r <= VEC_RST[1:0];
		end else if (ce_i) begin
			if (wb_wr && wb_i.adr == OFS_VEC_LO) begin
				vec_base_r[31:2] <= vec_lo_nxt[31:2];
				if (vec_lo_nxt[1:0] == MODE_VECTORED) begin
					vec_mode_r <= MODE_VECTORED;
				end else begin
					vec_mode_r <= MODE_DIRECT;
				end
			end else if (wb_wr && wb_i.adr == OFS_VEC_HI) begin
				vec_base_r[63:32] <= merge(vec_full[63:32], wb_i.dat, wb_i.sel);
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			len_r <= LEN_RST;
			gen_r <= GEN_RST;
		end else if (ce_i) begin
			if (wb_wr && wb_i.adr == OFS_LEN_LO) begin
				len_r[31:0] <= merge(len_r[31:0], wb_i.dat, wb_i.sel);
			end else if (wb_wr && wb_i.adr == OFS_LEN_HI) begin
				len_r[47:32] <= 16'(merge({16'h0, len_r[47:32]}, wb_i.dat, wb_i.sel));
			end else if (wb_wr && wb_i.adr == OFS_GEN) begin
				gen_r <= 6'(merge({26'h0, gen_r}, wb_i.dat, wb_i.sel));
			end
		end
	end

	// ---------------------------------------------------------------
	// Entry sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
			cnt_r   <= '0;
		end else if (ce_i) begin
			unique case (state_r)
				ST_IDLE: begin
					if (take) begin
						state_r <= ST_ENTRY;
						cnt_r   <= ENTRY_CYC - 3'h1;
					end
				end
				ST_ENTRY: begin
					if (cnt_r == 3'h0) begin
						state_r <= ST_HANDLER;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				ST_HANDLER: begin
					if (trap_ret_i) begin
						state_r <= ST_IDLE;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Trap outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			trap_taken_o <= 1'b0;
			trap_irq_o   <= 1'b0;
			handler_pc_o <= '0;
			fetch_req_o  <= 1'b0;
		end else if (ce_i) begin
			trap_taken_o <= take;
			fetch_req_o  <= (state_r == ST_ENTRY) && (cnt_r == 3'h0);
			if (take) begin
				trap_irq_o <= irq_any;
				if (irq_any && vec_mode_r == MODE_VECTORED) begin
					handler_pc_o <= {vec_base_r, 2'h0} + {irq_code[61:0], 2'h0};
				end else begin
					handler_pc_o <= {vec_base_r, 2'h0};
				end
			end
		end
	end

	// Divide keeps running; only a dependent handler read waits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stall_o <= 1'b0;
		end else if (ce_i) begin
			stall_o <= (state_r == ST_HANDLER) & div_busy_i & hdl_rs_valid_i &
				(hdl_rs_i == div_rd_i);
		end
	end

	// ---------------------------------------------------------------
	// Wishbone read and ack
	// ---------------------------------------------------------------
	logic [31:0] status_w;

	always_comb begin
		status_w     = '0;
		status_w[1]  = glb_s2_r.s_sw;
		status_w[3]  = glb_s2_r.m_sw;
		status_w[5]  = glb_s2_r.s_tim;
		status_w[7]  = glb_s2_r.m_tim;
		status_w[9]  = glb_s2_r.s_ext;
		status_w[11] = glb_s2_r.m_ext;
		status_w[16] = (state_r == ST_ENTRY);
		status_w[17] = (state_r == ST_HANDLER);
		status_w[18] = |loc_s2_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= wb_hit;
			if (wb_hit) begin
				unique case (wb_i.adr)
					OFS_CAUSE_LO: wb_dat_o <= cause_r[31:0];
					OFS_CAUSE_HI: wb_dat_o <= cause_r[63:32];
					OFS_VEC_LO:   wb_dat_o <= vec_full[31:0];
					OFS_VEC_HI:   wb_dat_o <= vec_full[63:32];
					OFS_LEN_LO:   wb_dat_o <= len_r[31:0];
					OFS_LEN_HI:   wb_dat_o <= {16'h0, len_r[47:32]};
					OFS_GEN:      wb_dat_o <= {26'h0, gen_r};
					OFS_STATUS:   wb_dat_o <= status_w;
					default:      wb_dat_o <= '0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// >>> src/ste_pkg.sv
// Constants and carrier types of the supervisor trap entry unit
`default_nettype none
package ste_pkg;
	// ---------------------------------------------------------------
	// Register map (byte addresses, 32-bit words)
	// ---------------------------------------------------------------
	localparam logic [5:0] OFS_CAUSE_LO = 6'h00;
	localparam logic [5:0] OFS_CAUSE_HI = 6'h04;
	localparam logic [5:0] OFS_VEC_LO   = 6'h08;
	localparam logic [5:0] OFS_VEC_HI   = 6'h0c;
	localparam logic [5:0] OFS_LEN_LO   = 6'h10;
	localparam logic [5:0] OFS_LEN_HI   = 6'h14;
	localparam logic [5:0] OFS_GEN      = 6'h18;
	localparam logic [5:0] OFS_STATUS   = 6'h1c;
	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int          CAUSE_IRQ_BIT = 63;
	localparam int          NUM_LOCAL     = 48;
	localparam int          NUM_GLOBAL    = 6;
	localparam logic [1:0]  MODE_DIRECT   = 2'h0;
	localparam logic [1:0]  MODE_VECTORED = 2'h1;
	localparam logic [63:0] CAUSE_RST     = 64'h0;
	localparam logic [63:0] VEC_RST       = 64'h0;
	localparam logic [47:0] LEN_RST       = 48'h0;
	localparam logic [5:0]  GEN_RST       = 6'h0;
	// ---------------------------------------------------------------
	// Interrupt cause codes
	// ---------------------------------------------------------------
	localparam logic [62:0] CODE_S_SW     = 63'h1;
	localparam logic [62:0] CODE_S_TIM    = 63'h5;
	localparam logic [62:0] CODE_S_EXT    = 63'h9;
	localparam logic [62:0] CODE_M_SW     = 63'h3;
	localparam logic [62:0] CODE_M_TIM    = 63'h7;
	localparam logic [62:0] CODE_M_EXT    = 63'hb;
	localparam logic [62:0] CODE_LOCAL0   = 63'h10;
	// Exception codes accepted from the pipeline
	localparam logic [4:0]  EXC_FETCH_MIS = 5'h0;
	localparam logic [4:0]  EXC_FETCH_ACC = 5'h1;
	localparam logic [4:0]  EXC_ILLEGAL   = 5'h2;
	localparam logic [4:0]  EXC_BREAK     = 5'h3;
	localparam logic [4:0]  EXC_LOAD_ACC  = 5'h5;
	localparam logic [4:0]  EXC_STORE_MIS = 5'h6;
	localparam logic [4:0]  EXC_STORE_ACC = 5'h7;
	localparam logic [4:0]  EXC_ECALL_U   = 5'h8;
	localparam logic [4:0]  EXC_FETCH_PF  = 5'hc;
	localparam logic [4:0]  EXC_LOAD_PF   = 5'hd;
	localparam logic [4:0]  EXC_STORE_PF  = 5'hf;
	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam logic [2:0]  ENTRY_CYC     = 3'h4;
	localparam int          CTRL_USER_CYC = 3;
	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [5:0]  adr;
		logic [3:0]  sel;
		logic [31:0] dat;
	} ste_wb_req_t;
	typedef struct packed {
		logic m_ext;
		logic m_sw;
		logic m_tim;
		logic s_ext;
		logic s_sw;
		logic s_tim;
	} ste_glb_t;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ENTRY,
		ST_HANDLER
	} ste_state_t;
endpackage
`default_nettype wire

// >>> tb/ste_trap_entry_asserts.sv
// Checker for the supervisor trap entry unit
`default_nettype none
module ste_trap_entry_asserts
	import ste_pkg::*;
#(
	parameter int USER_RATIO = 1            // Core clocks per user clock
) (
	input wire logic        clk_i,          // Core clock
	input wire logic        rst_i,          // Sync reset
	input wire logic        ce_i,           // Clock enable
	input wire ste_wb_req_t wb_i,           // Bus request
	input wire logic        wb_ack_o,       // Bus ack
	input wire logic        exc_valid_i,    // Exception
	input wire logic [4:0]  exc_code_i,     // Exception code
	input wire logic        div_busy_i,     // Divide busy
	input wire logic [4:0]  div_rd_i,       // Divide target
	input wire logic        hdl_rs_valid_i, // Handler read
	input wire logic [4:0]  hdl_rs_i,       // Handler source
	input wire logic        trap_taken_o,   // Trap pulse
	input wire logic        trap_irq_o,     // Interrupt flag
	input wire logic [63:0] handler_pc_o,   // Handler address
	input wire logic        fetch_req_o,    // Fetch pulse
	input wire logic        stall_o         // Stall
);
	logic dep;
	assign dep = div_busy_i && hdl_rs_valid_i && (hdl_rs_i == div_rd_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_quiet; !fetch_req_o [*3]; endsequence
	sequence s_fetch; s_quiet ##1 fetch_req_o ##1 !fetch_req_o; endsequence
	property p_entry_lat; trap_taken_o |=> s_fetch; endproperty
	property p_fetch_src; fetch_req_o |-> $past(trap_taken_o, 4); endproperty
	property p_taken_gap; trap_taken_o |=> !trap_taken_o [*4]; endproperty
	property p_pc_hold;
		$changed(handler_pc_o) || $changed(trap_irq_o) |-> trap_taken_o;
	endproperty
	property p_pc_align; trap_taken_o |-> handler_pc_o[1:0] == 2'h0; endproperty
	property p_exc_src;
		trap_taken_o && !trap_irq_o |-> $past(exc_valid_i) && $past(exc_code_i) inside
			{5'h0, 5'h1, 5'h2, 5'h3, [5'h5:5'h8], [5'hc:5'hd], 5'hf};
	endproperty
	property p_ack_resp; wb_i.cyc && wb_i.stb && !wb_ack_o && ce_i |=> wb_ack_o; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_stall; stall_o |-> $past(dep); endproperty
	a_entry_lat: assert property (p_entry_lat)
		else $error("handler fetch not four cycles after trap");
	a_fetch_src: assert property (p_fetch_src)
		else $error("handler fetch without trap");
	a_taken_gap: assert property (p_taken_gap)
		else $error("second trap during entry");
	a_pc_hold: assert property (p_pc_hold)
		else $error("trap outputs changed without trap");
	a_pc_align: assert property (p_pc_align)
		else $error("handler address not word aligned");
	a_exc_src: assert property (p_exc_src)
		else $error("exception trap without legal request");
	a_ack_resp: assert property (p_ack_resp)
		else $error("bus request not acknowledged");
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	a_stall: assert property (p_stall)
		else $error("stall without divide dependency");
endmodule
bind ste_trap_entry ste_trap_entry_asserts #(.USER_RATIO(USER_RATIO)) u_chk (
	.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i), .wb_ack_o(wb_ack_o),
	.exc_valid_i(exc_valid_i), .exc_code_i(exc_code_i), .div_busy_i(div_busy_i),
	.div_rd_i(div_rd_i), .hdl_rs_valid_i(hdl_rs_valid_i), .hdl_rs_i(hdl_rs_i),
	.trap_taken_o(trap_taken_o), .trap_irq_o(trap_irq_o),
	.handler_pc_o(handler_pc_o), .fetch_req_o(fetch_req_o), .stall_o(stall_o)
);
`default_nettype wire

// >>> tb/ste_irq_src.sv
// Model of the local sources and the interrupt controller lines
`default_nettype none
module ste_irq_src
	import ste_pkg::*;
(
	output logic [47:0] local_o, // Local levels
	output ste_glb_t    glb_o    // Controller lines
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		local_o = '0;
		glb_o = '0;
	end
	// Levels stay up until the bench calls clear
	task raise(input logic [47:0] l, input logic [5:0] g);
		local_o <= l;
		glb_o <= g;
	endtask
	task clear();
		local_o <= '0;
		glb_o <= '0;
	endtask
endmodule
`default_nettype wire

// >>> tb/ste_trap_entry_tb.sv
// Bench for the supervisor trap entry unit
`default_nettype none
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
	$display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module ste_trap_entry_tb;
	import ste_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int UR = 2;
	logic        clk_i = 0, rst_i = 1, exc_valid_i = 0, trap_ret_i = 0;
	logic        div_busy_i = 0, hdl_rs_valid_i = 0, vec = 0;
	logic [4:0]  exc_code_i = '0, div_rd_i = '0, hdl_rs_i = '0;
	ste_wb_req_t wb = '0;
	logic [47:0] local_irq;
	ste_glb_t    glb;
	logic [31:0] wb_dat_o, rexp;
	logic        wb_ack_o, trap_taken_o, trap_irq_o, fetch_req_o, stall_o;
	logic [63:0] handler_pc_o, base = 64'h1000;
	logic [64:0] texp;
	logic [15:0] rnd = 16'ha867;
	logic [31:0] rq[$];
	logic [64:0] tq[$];
	int          n_errors = 0, comparisons = 0, lat, glat, n, m;
	logic [4:0]  excs [11] = '{5'h0, 5'h1, 5'h2, 5'h3, 5'h5, 5'h6, 5'h7, 5'h8, 5'hc, 5'hd, 5'hf};
	logic [3:0]  gcode [6] = '{4'hb, 4'h3, 4'h7, 4'h9, 4'h1, 4'h5};
	always #50 clk_i = ~clk_i;
	function logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	ste_irq_src src (.local_o(local_irq), .glb_o(glb));
	ste_trap_entry #(.USER_RATIO(UR)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .local_irq_i(local_irq), .glb_irq_i(glb),
		.exc_valid_i(exc_valid_i), .exc_code_i(exc_code_i), .trap_ret_i(trap_ret_i),
		.div_busy_i(div_busy_i), .div_rd_i(div_rd_i), .hdl_rs_valid_i(hdl_rs_valid_i),
		.hdl_rs_i(hdl_rs_i), .trap_taken_o(trap_taken_o), .trap_irq_o(trap_irq_o),
		.handler_pc_o(handler_pc_o), .fetch_req_o(fetch_req_o), .stall_o(stall_o)
	);
	task finish_test();
		if (n_errors == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		wb <= '{1'b1, 1'b1, w, a, 4'hf, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		wb <= '0;
		@(posedge clk_i);
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		rq.push_back(e);
		bus(1'b0, a, '0);
	endtask
	// Waits for the trap, checks cause and stall, then returns
	task take(input logic irq, input logic [62:0] c);
		logic [4:0] r;
		tq.push_back({irq, irq && vec ? base + {c[60:0], 2'h0} : base});
		for (lat = 0; lat < 40 && trap_taken_o !== 1'b1; lat++) @(posedge clk_i);
		`CHK(trap_taken_o, 1'b1)
		src.clear();
		exc_valid_i <= 1'b0;
		rd(OFS_CAUSE_LO, c[31:0]);
		rd(OFS_CAUSE_HI, {irq, c[62:32]});
		rnd = lfsr(rnd);
		r = {4'h2, rnd[0]};
		div_busy_i <= 1'b1;
		hdl_rs_valid_i <= 1'b1;
		div_rd_i <= 5'h5;
		hdl_rs_i <= r;
		@(posedge clk_i);
		div_busy_i <= 1'b0;
		hdl_rs_valid_i <= 1'b0;
		@(posedge clk_i);
		`CHK(stall_o, r == 5'h5)
		trap_ret_i <= 1'b1;
		@(posedge clk_i);
		trap_ret_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb.we === 1'b0) begin
			rexp = rq.size() ? rq.pop_front() : 'x;
			`CHK(wb_dat_o, rexp)
		end
		if (trap_taken_o === 1'b1) begin
			texp = tq.size() ? tq.pop_front() : 'x;
			`CHK({trap_irq_o, handler_pc_o}, texp)
		end
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		finish_test();
	end
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(OFS_CAUSE_HI, 32'h0);
		rd(OFS_VEC_LO, 32'h0);
		bus(1'b1, OFS_VEC_LO, 32'h1003);
		rd(OFS_VEC_LO, 32'h1000);
		bus(1'b1, OFS_VEC_LO, 32'h1002);
		rd(OFS_VEC_LO, 32'h1000);
		rd(6'h3c, 32'h0);
		// Pending view of the external line while globals are still disabled
		src.raise('0, 6'h04);
		repeat (3) @(posedge clk_i);
		rd(OFS_STATUS, 32'h200);
		src.clear();
		bus(1'b1, OFS_LEN_LO, 32'hffff_ffff);
		bus(1'b1, OFS_LEN_HI, 32'hffff);
		bus(1'b1, OFS_GEN, 32'h3f);
		foreach (excs[i]) begin
			exc_valid_i <= 1'b1;
			exc_code_i <= excs[i];
			take(1'b0, 63'(excs[i]));
		end
		// Reserved code must not start a trap
		exc_valid_i <= 1'b1;
		exc_code_i <= 5'h4;
		repeat (10) @(posedge clk_i);
		exc_valid_i <= 1'b0;
		src.raise('0, 6'h01);
		take(1'b1, 63'h5);
		bus(1'b1, OFS_VEC_LO, 32'h1001);
		vec = 1'b1;
		for (int i = 0; i < 6; i++) begin
			src.raise('0, 6'h3f >> i);
			take(1'b1, 63'(gcode[i]));
		end
		glat = lat;
		for (int i = 0; i < 4; i++) begin
			rnd = lfsr(rnd);
			n = (i == 0) ? 47 : rnd % 48;
			m = (i == 0) ? 6 : rnd[15:8] % 48;
			src.raise((48'h1 << n) | (48'h1 << m), 6'h3f);
			take(1'b1, 63'(16 + (n > m ? n : m)));
		end
		`CHK(glat - lat, 3 * UR)
		// Exceptions ignore vectoring
		exc_valid_i <= 1'b1;
		exc_code_i <= EXC_ILLEGAL;
		take(1'b0, 63'(EXC_ILLEGAL));
		`CHK(rq.size() + tq.size(), 0)
		finish_test();
	end
endmodule
`default_nettype wire
